// file: src/blsa_pkg.sv
// Package for the byte logic, shift and bit datapath: operation codes, field widths, bit positions and the flag reset value.
// Assumes a single clock domain shared with the instruction sequencer.
package blsa_pkg;
   localparam int BLSA_DW = 8;
   localparam int BLSA_BNW = 3;
   localparam int BLSA_MSB = 7;
   localparam int BLSA_LSB = 0;
   localparam logic [BLSA_DW-1:0] BLSA_ZERO_BYTE = 8'h00;
   localparam logic [BLSA_DW-1:0] BLSA_ONE_HOT = 8'h01;
   localparam logic BLSA_FLAG_RST = 1'h0;

   typedef enum logic [4:0] {
      BLSA_OP_AND,
      BLSA_OP_OR,
      BLSA_OP_XOR,
      BLSA_OP_NOT,
      BLSA_OP_ARITH_SHIFT_LEFT,
      BLSA_OP_ARITH_SHIFT_RIGHT,
      BLSA_OP_LOGIC_SHIFT_LEFT,
      BLSA_OP_LOGIC_SHIFT_RIGHT,
      BLSA_OP_ROTATE_LEFT,
      BLSA_OP_ROTATE_RIGHT,
      BLSA_OP_ROTATE_CARRY_LEFT,
      BLSA_OP_ROTATE_CARRY_RIGHT,
      BLSA_OP_BIT_SET,
      BLSA_OP_BIT_CLEAR,
      BLSA_OP_BIT_INVERT,
      BLSA_OP_BIT_TEST,
      BLSA_OP_CARRY_AND_BIT,
      BLSA_OP_CARRY_AND_INV_BIT,
      BLSA_OP_CARRY_OR_BIT,
      BLSA_OP_CARRY_OR_INV_BIT
   } blsa_op_t;
endpackage : blsa_pkg

// file: src/blsa_bit_sel.sv
// Bit-number selection and one-hot mask for the bit operations.
// Assumes the bit number source is held steady while the request is valid.
`timescale 1ns/1ps
module blsa_bit_sel #(
   parameter int DW = 8,
   parameter int BNW = 3
) (
   // Sources of the bit number
   input wire logic [BNW-1:0] imm_bit_i,
   input wire logic [DW-1:0] reg_bit_i,
   input wire logic use_reg_i,
   // Selected operand
   input wire logic [DW-1:0] operand_i,
   // Results
   output logic [DW-1:0] mask_o,
   output logic bit_o
);
   import blsa_pkg::*;
   logic [BNW-1:0] bit_num;

   always_comb begin
      bit_num = use_reg_i ? reg_bit_i[BNW-1:0] : imm_bit_i;
      mask_o = DW'(BLSA_ONE_HOT) << bit_num;
      bit_o = operand_i[bit_num];
   end
endmodule : blsa_bit_sel

// file: src/blsa_shifter.sv
// One-position shift and rotate unit with carry out and overflow.
// Assumes a byte operand and the current carry flag.
`timescale 1ns/1ps
module blsa_shifter (
   // Operation and operands
   input wire blsa_pkg::blsa_op_t op_i,
   input wire logic [blsa_pkg::BLSA_DW-1:0] value_i,
   input wire logic carry_i,
   // Results
   output logic [blsa_pkg::BLSA_DW-1:0] result_o,
   output logic carry_o,
   output logic overflow_o
);
   import blsa_pkg::*;
   logic out_left;
   logic out_right;

   always_comb begin
      out_left = value_i[BLSA_MSB];
      out_right = value_i[BLSA_LSB];
      result_o = value_i;
      carry_o = carry_i;
      overflow_o = 1'b0;
      unique case (op_i)
         BLSA_OP_ARITH_SHIFT_LEFT: begin
            result_o = {value_i[BLSA_MSB-1:0], 1'b0};
            carry_o = out_left;
            overflow_o = value_i[BLSA_MSB] ^ value_i[BLSA_MSB-1];
         end
         BLSA_OP_ARITH_SHIFT_RIGHT: begin
            result_o = {value_i[BLSA_MSB], value_i[BLSA_MSB:1]};
            carry_o = out_right;
         end
         BLSA_OP_LOGIC_SHIFT_LEFT: begin
            result_o = {value_i[BLSA_MSB-1:0], 1'b0};
            carry_o = out_left;
         end
         BLSA_OP_LOGIC_SHIFT_RIGHT: begin
            result_o = {1'b0, value_i[BLSA_MSB:1]};
            carry_o = out_right;
         end
         BLSA_OP_ROTATE_LEFT: begin
            result_o = {value_i[BLSA_MSB-1:0], out_left};
            carry_o = out_left;
         end
         BLSA_OP_ROTATE_RIGHT: begin
            result_o = {out_right, value_i[BLSA_MSB:1]};
            carry_o = out_right;
         end
         BLSA_OP_ROTATE_CARRY_LEFT: begin
            result_o = {value_i[BLSA_MSB-1:0], carry_i};
            carry_o = out_left;
         end
         BLSA_OP_ROTATE_CARRY_RIGHT: begin
            result_o = {carry_i, value_i[BLSA_MSB:1]};
            carry_o = out_right;
         end
         default: begin
            result_o = value_i;
         end
      endcase
   end
endmodule : blsa_shifter

// file: src/blsa_alu.sv
// Byte-wide logic, shift, rotate and bit-manipulation datapath with registered result and flags.
// Assumes the sequencer presents operands and a one-cycle request, and takes the result one cycle later.
`timescale 1ns/1ps
// Notes on behaviour
// - AND destination with register or immediate
// - OR destination with register or immediate
// - XOR destination with register or immediate
// - Complement inverts every destination bit
// - Arithmetic shifts; right keeps sign bit
// - Logical shifts fill vacated bit with zero
// - Rotate: outgoing bit re-enters other end
// - Rotate through carry as nine-bit ring
// - Bit number from immediate or register
// - Bit set forces selected bit to one
// - Bit clear forces selected bit to zero
// - Bit invert toggles selected bit
// - Bit test loads zero flag inverted bit
// - Carry ANDed with selected bit
// - Carry ANDed with inverted selected bit
// - Carry ORed with selected bit
// - Carry ORed with inverted selected bit
// - Inverted carry ops use immediate only
module blsa_alu (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Request
   input wire logic req_valid_i,
   input wire blsa_pkg::blsa_op_t op_i,
   input wire logic [blsa_pkg::BLSA_DW-1:0] dest_i,
   input wire logic [blsa_pkg::BLSA_DW-1:0] source_register_i,
   input wire logic [blsa_pkg::BLSA_DW-1:0] immediate_operand_i,
   input wire logic use_immediate_i,
   input wire logic [blsa_pkg::BLSA_BNW-1:0] bit_imm_i,
   input wire logic bit_from_reg_i,
   // Flags in
   input wire logic carry_i,
   input wire logic zero_i,
   input wire logic neg_i,
   input wire logic ovf_i,
   // Result
   output logic done_o,
   output logic write_o,
   output logic [blsa_pkg::BLSA_DW-1:0] result_o,
   output logic carry_o,
   output logic zero_o,
   output logic neg_o,
   output logic ovf_o
);
   import blsa_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Operand selection and sub-units
   logic [BLSA_DW-1:0] src_byte;
   logic [BLSA_DW-1:0] bit_mask;
   logic sel_bit;
   logic [BLSA_DW-1:0] sh_result;
   logic sh_carry;
   logic sh_ovf;
   logic reg_bit_ok;

   assign src_byte = use_immediate_i ? immediate_operand_i : source_register_i;
   // Inverted carry operations never take the bit number from a register
   assign reg_bit_ok = bit_from_reg_i && (op_i != BLSA_OP_CARRY_AND_INV_BIT)
                       && (op_i != BLSA_OP_CARRY_OR_INV_BIT);

   blsa_bit_sel #(
      .DW(BLSA_DW),
      .BNW(BLSA_BNW)
   ) u_bit_sel (
      .imm_bit_i(bit_imm_i),
      .reg_bit_i(source_register_i),
      .use_reg_i(reg_bit_ok),
      .operand_i(dest_i),
      .mask_o(bit_mask),
      .bit_o(sel_bit)
   );

   blsa_shifter u_shifter (
      .op_i(op_i),
      .value_i(dest_i),
      .carry_i(carry_i),
      .result_o(sh_result),
      .carry_o(sh_carry),
      .overflow_o(sh_ovf)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-value computation
   logic next_done;
   logic next_write;
   logic [BLSA_DW-1:0] next_result;
   logic next_carry;
   logic next_zero;
   logic next_neg;
   logic next_ovf;

   always_comb begin
      next_done = req_valid_i;
      next_write = 1'b0;
      next_result = result_o;
      next_carry = carry_o;
      next_zero = zero_o;
      next_neg = neg_o;
      next_ovf = ovf_o;
      if (req_valid_i) begin
         next_result = dest_i;
         next_carry = carry_i;
         next_zero = zero_i;
         next_neg = neg_i;
         next_ovf = ovf_i;
         unique case (op_i)
            BLSA_OP_AND: begin
               next_result = dest_i & src_byte;
               next_write = 1'b1;
            end
            BLSA_OP_OR: begin
               next_result = dest_i | src_byte;
               next_write = 1'b1;
            end
            BLSA_OP_XOR: begin
               next_result = dest_i ^ src_byte;
               next_write = 1'b1;
            end
            BLSA_OP_NOT: begin
               next_result = ~dest_i;
               next_write = 1'b1;
            end
            BLSA_OP_ARITH_SHIFT_LEFT, BLSA_OP_ARITH_SHIFT_RIGHT,
            BLSA_OP_LOGIC_SHIFT_LEFT, BLSA_OP_LOGIC_SHIFT_RIGHT,
            BLSA_OP_ROTATE_LEFT, BLSA_OP_ROTATE_RIGHT,
            BLSA_OP_ROTATE_CARRY_LEFT, BLSA_OP_ROTATE_CARRY_RIGHT: begin
               next_result = sh_result;
               next_carry = sh_carry;
               next_write = 1'b1;
            end
            BLSA_OP_BIT_SET: begin
               next_result = dest_i | bit_mask;
               next_write = 1'b1;
            end
            BLSA_OP_BIT_CLEAR: begin
               next_result = dest_i & ~bit_mask;
               next_write = 1'b1;
            end
            BLSA_OP_BIT_INVERT: begin
               next_result = dest_i ^ bit_mask;
               next_write = 1'b1;
            end
            BLSA_OP_BIT_TEST: begin
               next_zero = ~sel_bit;
            end
            BLSA_OP_CARRY_AND_BIT: begin
               next_carry = carry_i & sel_bit;
            end
            BLSA_OP_CARRY_AND_INV_BIT: begin
               next_carry = carry_i & ~sel_bit;
            end
            BLSA_OP_CARRY_OR_BIT: begin
               next_carry = carry_i | sel_bit;
            end
            BLSA_OP_CARRY_OR_INV_BIT: begin
               next_carry = carry_i | ~sel_bit;
            end
            default: begin
               next_write = 1'b0;
            end
         endcase
         // Logic, shift and rotate set N and Z from the result
         if (op_i <= BLSA_OP_ROTATE_CARRY_RIGHT) begin
            next_neg = next_result[BLSA_MSB];
            next_zero = (next_result == BLSA_ZERO_BYTE);
            next_ovf = (op_i == BLSA_OP_ARITH_SHIFT_LEFT) ? sh_ovf : 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_o <= 1'b0;
         write_o <= 1'b0;
         result_o <= BLSA_ZERO_BYTE;
         carry_o <= BLSA_FLAG_RST;
         zero_o <= BLSA_FLAG_RST;
         neg_o <= BLSA_FLAG_RST;
         ovf_o <= BLSA_FLAG_RST;
      end else begin
         done_o <= next_done;
         write_o <= next_write;
         result_o <= next_result;
         carry_o <= next_carry;
         zero_o <= next_zero;
         neg_o <= next_neg;
         ovf_o <= next_ovf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_and_result: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_AND |=> result_o == ($past(dest_i) & $past(src_byte)) && write_o)
      else $error("AND result wrong");
   chk_or_result: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_OR |=> result_o == ($past(dest_i) | $past(src_byte)))
      else $error("OR result wrong");
   chk_xor_result: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_XOR |=> result_o == ($past(dest_i) ^ $past(src_byte)))
      else $error("XOR result wrong");
   chk_not_result: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_NOT |=> result_o == ~$past(dest_i))
      else $error("complement result wrong");
   chk_asr_sign: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ARITH_SHIFT_RIGHT |=> result_o[7] == $past(dest_i[7]) && carry_o == $past(dest_i[0]))
      else $error("arithmetic right shift wrong");
   chk_lsr_fill: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_LOGIC_SHIFT_RIGHT |=> result_o[7] == 1'b0 && result_o[6:0] == $past(dest_i[7:1]))
      else $error("logical right shift wrong");
   chk_rotate_left_wrap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ROTATE_LEFT |=> result_o == {$past(dest_i[6:0]), $past(dest_i[7])})
      else $error("rotate left wrong");
   chk_rotate_carry_left_ring: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ROTATE_CARRY_LEFT |=> {carry_o, result_o} == {$past(dest_i), $past(carry_i)})
      else $error("rotate through carry wrong");
   chk_bit_set: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_BIT_SET && !bit_from_reg_i
      |=> result_o == ($past(dest_i) | (8'h01 << $past(bit_imm_i))))
      else $error("bit set wrong");
   chk_bit_test: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_BIT_TEST
      |=> zero_o == ~$past(dest_i[bit_from_reg_i ? source_register_i[2:0] : bit_imm_i]) && !write_o)
      else $error("bit test wrong");
   chk_carry_and_inv_bit_imm: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_CARRY_AND_INV_BIT
      |=> carry_o == ($past(carry_i) & ~$past(dest_i[bit_imm_i])))
      else $error("inverted carry AND wrong");
   chk_logic_ovf: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i <= BLSA_OP_NOT |=> !ovf_o && zero_o == (result_o == 8'h00))
      else $error("logic flags wrong");

   ////////////////////////////////////////////////////////////////////////////////
   // Shift, bit and carry checks
   chk_asl_result: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ARITH_SHIFT_LEFT |=> result_o == {$past(dest_i[6:0]), 1'b0})
      else $error("arithmetic left shift wrong");
   chk_lsl_fill: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_LOGIC_SHIFT_LEFT |=> result_o == {$past(dest_i[6:0]), 1'b0})
      else $error("logical left shift wrong");
   chk_rotate_right_wrap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ROTATE_RIGHT |=> result_o == {$past(dest_i[0]), $past(dest_i[7:1])})
      else $error("rotate right wrong");
   chk_rotate_carry_right_ring: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ROTATE_CARRY_RIGHT |=> {result_o, carry_o} == {$past(carry_i), $past(dest_i)})
      else $error("rotate right through carry wrong");
   chk_bit_regnum: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_BIT_SET && bit_from_reg_i
      |=> result_o == ($past(dest_i) | (8'h01 << $past(source_register_i[2:0]))))
      else $error("register bit number wrong");
   chk_bit_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_BIT_CLEAR && !bit_from_reg_i |=> result_o == ($past(dest_i) & ~(8'h01 << $past(bit_imm_i))))
      else $error("bit clear wrong");
   chk_bit_invert: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_BIT_INVERT && !bit_from_reg_i |=> result_o == ($past(dest_i) ^ (8'h01 << $past(bit_imm_i))))
      else $error("bit invert wrong");
   chk_bit_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i >= BLSA_OP_BIT_SET && op_i <= BLSA_OP_BIT_INVERT
      |=> write_o && {carry_o, zero_o, neg_o, ovf_o} == $past({carry_i, zero_i, neg_i, ovf_i}))
      else $error("bit operation flags wrong");
   chk_test_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_BIT_TEST |=> result_o == $past(dest_i) && carry_o == $past(carry_i))
      else $error("bit test changed operand");
   chk_band_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_CARRY_AND_BIT && !bit_from_reg_i |=> carry_o == ($past(carry_i) & $past(dest_i[bit_imm_i])))
      else $error("carry AND wrong");
   chk_carry_only: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i >= BLSA_OP_CARRY_AND_BIT
      |=> !write_o && result_o == $past(dest_i) && {zero_o, neg_o, ovf_o} == $past({zero_i, neg_i, ovf_i}))
      else $error("carry operation touched other state");
   chk_bor_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_CARRY_OR_BIT && !bit_from_reg_i |=> carry_o == ($past(carry_i) | $past(dest_i[bit_imm_i])))
      else $error("carry OR wrong");
   chk_carry_or_inv_bit_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_CARRY_OR_INV_BIT |=> carry_o == ($past(carry_i) | ~$past(dest_i[bit_imm_i])))
      else $error("inverted carry OR wrong");
   chk_left_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && (op_i == BLSA_OP_LOGIC_SHIFT_LEFT || op_i == BLSA_OP_ROTATE_LEFT) |=> carry_o == $past(dest_i[7]))
      else $error("left carry out wrong");
   chk_right_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && (op_i == BLSA_OP_LOGIC_SHIFT_RIGHT || op_i == BLSA_OP_ROTATE_RIGHT) |=> carry_o == $past(dest_i[0]))
      else $error("right carry out wrong");
   chk_asl_ovf: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ARITH_SHIFT_LEFT |=> ovf_o == ($past(dest_i[7]) ^ $past(dest_i[6])) && neg_o == result_o[7])
      else $error("arithmetic left shift flags wrong");
   chk_shift_flags: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i >= BLSA_OP_ARITH_SHIFT_RIGHT && op_i <= BLSA_OP_ROTATE_CARRY_RIGHT
      |=> !ovf_o && neg_o == result_o[7] && zero_o == (result_o == 8'h00))
      else $error("shift flags wrong");
   cov_rotate_carry_right: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ROTATE_CARRY_RIGHT && carry_i);
   cov_asl_ovf: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_ARITH_SHIFT_LEFT ##1 ovf_o);
   cov_bit_reg: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i && op_i == BLSA_OP_BIT_INVERT && bit_from_reg_i);
   cov_b2b: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      req_valid_i ##1 req_valid_i);
endmodule : blsa_alu

// file: tb/blsa_seq_model.sv
// Sequencer-side model: one general register and the flag bits that feed the datapath.
// Assumes the bench preloads it and the datapath answers with done_o and write_o.
`timescale 1ns/1ps
module blsa_seq_model (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Preload from the bench
   input wire logic ld_i,
   input wire logic [7:0] ld_reg_i,
   input wire logic [3:0] ld_flags_i,
   // Answer from the datapath
   input wire logic done_i,
   input wire logic write_i,
   input wire logic [7:0] result_i,
   input wire logic [3:0] flags_i,
   // State shown to the datapath
   output logic [7:0] reg_o,
   output logic [3:0] flags_o
);
   logic [7:0] next_reg;
   logic [3:0] next_flags;
   always_comb begin
      next_reg = reg_o;
      next_flags = flags_o;
      if (ld_i) begin
         next_reg = ld_reg_i;
         next_flags = ld_flags_i;
      end else if (done_i) begin
         next_flags = flags_i;
         if (write_i) begin
            next_reg = result_i;
         end
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_o <= 8'h00;
         flags_o <= 4'h0;
      end else begin
         reg_o <= next_reg;
         flags_o <= next_flags;
      end
   end
endmodule : blsa_seq_model

// file: tb/tb_top.sv
// Self-checking bench for the byte logic, shift and bit datapath.
// Assumes the sequencer model in blsa_seq_model supplies operand and flags.
`timescale 1ns/1ps
module tb_top;
   import blsa_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic req = 1'b0, ui = 1'b0, br = 1'b0, ld = 1'b0;
   blsa_op_t op = BLSA_OP_AND;
   logic [7:0] src = 8'h00, imm = 8'h00, ld_reg = 8'h00, m_reg, result_o;
   logic [2:0] bimm = 3'h0;
   logic [3:0] ld_flags = 4'h0, m_flags;
   logic done_o, write_o, carry_o, zero_o, neg_o, ovf_o;
   int fail_count = 0;
   int total_checks = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   blsa_seq_model u_seq (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ld_i(ld), .ld_reg_i(ld_reg),
      .ld_flags_i(ld_flags), .done_i(done_o), .write_i(write_o), .result_i(result_o),
      .flags_i({carry_o, zero_o, neg_o, ovf_o}), .reg_o(m_reg), .flags_o(m_flags));
   blsa_alu DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req), .op_i(op), .dest_i(m_reg),
      .source_register_i(src), .immediate_operand_i(imm), .use_immediate_i(ui), .bit_imm_i(bimm),
      .bit_from_reg_i(br), .carry_i(m_flags[3]), .zero_i(m_flags[2]), .neg_i(m_flags[1]), .ovf_i(m_flags[0]),
      .done_o(done_o), .write_o(write_o), .result_o(result_o), .carry_o(carry_o), .zero_o(zero_o),
      .neg_o(neg_o), .ovf_o(ovf_o));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   // Expected {write, result, c, z, n, v}
   function automatic logic [12:0] exp_op(blsa_op_t o, logic [7:0] d, logic [7:0] s, logic [2:0] b,
      logic [3:0] f);
      logic [7:0] r;
      logic w, c, z;
      r = d;
      w = 1'b1;
      c = f[3];
      z = f[2];
      case (o)
         BLSA_OP_AND: r = d & s;
         BLSA_OP_OR: r = d | s;
         BLSA_OP_XOR: r = d ^ s;
         BLSA_OP_NOT: r = ~d;
         BLSA_OP_ARITH_SHIFT_LEFT, BLSA_OP_LOGIC_SHIFT_LEFT: {c, r} = {d, 1'b0};
         BLSA_OP_ARITH_SHIFT_RIGHT: {r, c} = {d[7], d};
         BLSA_OP_LOGIC_SHIFT_RIGHT: {r, c} = {1'b0, d};
         BLSA_OP_ROTATE_LEFT: {c, r} = {d[7], d[6:0], d[7]};
         BLSA_OP_ROTATE_RIGHT: {r, c} = {d[0], d};
         BLSA_OP_ROTATE_CARRY_LEFT: {c, r} = {d, f[3]};
         BLSA_OP_ROTATE_CARRY_RIGHT: {r, c} = {f[3], d};
         BLSA_OP_BIT_SET: r[b] = 1'b1;
         BLSA_OP_BIT_CLEAR: r[b] = 1'b0;
         BLSA_OP_BIT_INVERT: r[b] = ~d[b];
         BLSA_OP_BIT_TEST: {w, z} = {1'b0, ~d[b]};
         BLSA_OP_CARRY_AND_BIT: {w, c} = {1'b0, f[3] & d[b]};
         BLSA_OP_CARRY_AND_INV_BIT: {w, c} = {1'b0, f[3] & ~d[b]};
         BLSA_OP_CARRY_OR_BIT: {w, c} = {1'b0, f[3] | d[b]};
         default: {w, c} = {1'b0, f[3] | ~d[b]};
      endcase
      if (o <= BLSA_OP_ROTATE_CARRY_RIGHT) begin
         return {w, r, c, r == 8'h00, r[7], o == BLSA_OP_ARITH_SHIFT_LEFT && (d[7] ^ d[6])};
      end
      return {w, r, c, z, f[1:0]};
   endfunction : exp_op
   // One preload, one request, then result and write-back checks
   task automatic do_op(input blsa_op_t o, input logic [7:0] d, s, im, input logic u, input logic [2:0] bi,
      input logic b, input logic [3:0] f);
      logic [12:0] e;
      logic [2:0] bn;
      bn = (b && o != BLSA_OP_CARRY_AND_INV_BIT && o != BLSA_OP_CARRY_OR_INV_BIT) ? s[2:0] : bi;
      e = exp_op(o, d, u ? im : s, bn, f);
      @(negedge sys_clk_i);
      {ld, ld_reg, ld_flags} = {1'b1, d, f};
      @(negedge sys_clk_i);
      op = o;
      {ld, req, src, imm, ui, bimm, br} = {1'b0, 1'b1, s, im, u, bi, b};
      @(negedge sys_clk_i);
      req = 1'b0;
      chk("done", 8'h01, {7'h00, done_o});
      chk("write", {7'h00, e[12]}, {7'h00, write_o});
      chk("result", e[11:4], result_o);
      chk("flags", {4'h0, e[3:0]}, {4'h0, carry_o, zero_o, neg_o, ovf_o});
      @(negedge sys_clk_i);
      chk("done_end", 8'h00, {7'h00, done_o});
      chk("wb_reg", e[11:4], m_reg);
      chk("wb_flags", {4'h0, e[3:0]}, {4'h0, m_flags});
   endtask : do_op
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_logic;
      for (int k = 0; k < 3; k++) begin
         do_op(blsa_op_t'(k), 8'hF0, 8'h3C, 8'hA5, 1'b0, 3'h0, 1'b0, 4'hF);
         do_op(blsa_op_t'(k), 8'h5A, 8'h3C, 8'hA5, 1'b1, 3'h0, 1'b0, 4'h0);
      end
      do_op(BLSA_OP_NOT, 8'h5A, 8'h00, 8'h00, 1'b0, 3'h0, 1'b0, 4'h1);
      do_op(BLSA_OP_NOT, 8'hFF, 8'h00, 8'h00, 1'b1, 3'h0, 1'b0, 4'h8);
      $display("test_logic done");
   endtask : test_logic
   task automatic test_shift;
      logic [7:0] vals [3] = '{8'h81, 8'h40, 8'hC0};
      for (int k = 4; k < 12; k++) foreach (vals[i]) for (int c = 0; c < 2; c++) begin
         do_op(blsa_op_t'(k), vals[i], 8'h00, 8'h00, 1'b0, 3'h0, 1'b0, {c[0], 3'h5});
      end
      $display("test_shift done");
   endtask : test_shift
   task automatic test_bits;
      for (int k = 12; k < 16; k++) for (int b = 0; b < 8; b++) begin
         do_op(blsa_op_t'(k), 8'h5A, 8'h00, 8'h00, 1'b0, b[2:0], 1'b0, 4'h5);
         do_op(blsa_op_t'(k), 8'hA5, {5'h1F, b[2:0]}, 8'h00, 1'b0, ~b[2:0], 1'b1, 4'hA);
      end
      $display("test_bits done");
   endtask : test_bits
   task automatic test_carry;
      for (int k = 16; k < 20; k++) for (int c = 0; c < 2; c++) for (int b = 1; b < 7; b += 5) begin
         do_op(blsa_op_t'(k), 8'h0F, 8'h00, 8'h00, 1'b0, b[2:0], 1'b0, {c[0], 3'h6});
         do_op(blsa_op_t'(k), 8'h0F, {5'h00, ~b[2:0]}, 8'h00, 1'b0, b[2:0], 1'b1, {c[0], 3'h1});
      end
      $display("test_carry done");
   endtask : test_carry
   task automatic test_idle_b2b;
      do_op(BLSA_OP_OR, 8'h12, 8'h21, 8'h00, 1'b0, 3'h0, 1'b0, 4'h0);
      op = BLSA_OP_NOT;
      {src, imm, ui} = {8'hFF, 8'hFF, 1'b1};
      repeat (3) @(negedge sys_clk_i);
      chk("idle_done", 8'h00, {7'h00, done_o});
      chk("idle_result", 8'h33, result_o);
      req = 1'b1;
      op = BLSA_OP_ROTATE_LEFT;
      @(negedge sys_clk_i);
      op = BLSA_OP_LOGIC_SHIFT_RIGHT;
      chk("b2b_first", 8'h66, result_o);
      @(negedge sys_clk_i);
      req = 1'b0;
      chk("b2b_done", 8'h01, {7'h00, done_o});
      chk("b2b_second", 8'h19, result_o);
      $display("test_idle_b2b done");
   endtask : test_idle_b2b
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(negedge sys_clk_i);
      chk("rst_out", 8'h00, result_o | {done_o, write_o, carry_o, zero_o, neg_o, ovf_o, 2'h0});
      rst_b_i = 1'b1;
      test_logic();
      test_shift();
      test_bits();
      test_carry();
      test_idle_b2b();
      test_done();
   end
   initial begin
      #200000;
      fail_count++;
      test_done();
   end
endmodule : tb_top
